//--- mpu_memory_map_sfr_decode.sv
// Internal memory, register file and address decode for the 8-bit core
`include "mpu_memory_map_map.svh"
module mpu_memory_map_sfr_decode
    import mpu_memory_map_pkg::*;
#(
    parameter int VEC_W = 4,
    parameter int CE_BASE_KB = 0,
    parameter int CE_SIZE_KB = 3
) (
    input wire logic clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire int_req_s int_req,
    output logic [7:0] int_rdata,
    output logic int_rvalid,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [7:0] push_data,
    input wire xreq_s xreq,
    output xbus_s xbus,
    input wire logic [7:0] xrdata,
    input wire logic xrdata_valid,
    output logic xbusy,
    input wire logic pc_load,
    input wire logic [15:0] pc_target,
    input wire logic pc_inc,
    input wire logic irq_take,
    input wire logic [VEC_W-1:0] irq_index,
    input wire logic movc_req,
    input wire logic movc_use_pc,
    output logic [15:0] fetch_addr,
    output logic [15:0] code_addr,
    output logic code_in_ce,
    input wire flag_upd_s flag_upd,
    input wire logic muldiv_we,
    input wire logic [7:0] muldiv_acc,
    input wire logic [7:0] muldiv_aux,
    output logic [7:0] accumulator,
    output logic [1:0] bank_sel
);

    logic [7:0] sfr_ff [0:127];
    logic [7:0] iram_ff [0:255];
    logic [7:0] int_rdata_ff;
    logic int_rvalid_ff;
    xbus_s xbus_ff;
    xstate_e xstate_ff;
    xstate_e nxt_xstate;
    logic [15:0] pc_ff;
    logic [15:0] code_addr_ff;
    logic code_in_ce_ff;

    logic [7:0] acc;
    logic [7:0] psw_view;
    logic [7:0] sp;
    logic [15:0] data_pointer_zero_sel;
    logic [7:0] ri_val;
    logic [15:0] x_addr;
    logic [16:0] ce_lo;
    logic [16:0] ce_end;
    logic [16:0] code_next;
    logic [7:0] sfr_rd;
    logic [7:0] bit_tgt;
    logic [7:0] bit_old;
    logic sfr_wr;
    logic iram_wr;
    logic bit_wr_sfr;
    logic bit_wr_iram;
    logic [7:0] bit_new;
    logic x_start;

    function automatic logic [6:0] ix(input logic [7:0] a);
        return a[6:0];
    endfunction

    // Table of implemented register addresses
    function automatic logic sfr_impl(input logic [7:0] a);
        case (a)
            `SFR_GPIO_A, `SFR_STACK, `SFR_DP0_LO, `SFR_DP0_HI, `SFR_DP1_LO,
            `SFR_DP1_HI, `SFR_PWR_BAUD, `SFR_TMR_RUN, `SFR_TMR_MODE,
            `SFR_TMR0_LO, `SFR_TMR1_LO, `SFR_TMR0_HI, `SFR_TMR1_HI,
            `SFR_STRETCH, `SFR_GPIO_B, `SFR_PTR_SEL, `SFR_SER0_CTL,
            `SFR_SER0_BUF, `SFR_IRQ_EN2, `SFR_SER1_CTL, `SFR_SER1_BUF,
            `SFR_SER1_RL_LO, `SFR_GPIO_C, `SFR_IRQ_EN0, `SFR_IRQ_PRI0,
            `SFR_SER0_RL_LO, `SFR_GPIO_D, `SFR_IRQ_EN1, `SFR_IRQ_PRI1,
            `SFR_SER0_RL_HI, `SFR_SER1_RL_HI, `SFR_XPAGE, `SFR_IRQ_REQ,
            `SFR_EXT_POL, `SFR_STATUS_WORD, `SFR_BAUD_SRC, `SFR_ACCUM,
            `SFR_MUL_AUX: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    function automatic logic [7:0] sfr_rst(input logic [7:0] a);
        case (a)
            `SFR_GPIO_A, `SFR_GPIO_B, `SFR_GPIO_C, `SFR_GPIO_D: begin
                return `RST_GPIO;
            end
            `SFR_STACK: begin
                return `RST_STACK;
            end
            `SFR_STRETCH: begin
                return `RST_STRETCH;
            end
            `SFR_SER0_RL_LO: begin
                return `RST_SER0_RL_LO;
            end
            `SFR_SER0_RL_HI, `SFR_SER1_RL_HI: begin
                return `RST_SERX_RL_HI;
            end
            default: begin
                return 8'h00;
            end
        endcase
    endfunction

    // Software-writable bits; parity is hardware owned
    function automatic logic [7:0] sfr_wmask(input logic [7:0] a);
        case (a)
            `SFR_BAUD_SRC: begin
                return `BAUD_SRC_WMASK;
            end
            `SFR_STATUS_WORD: begin
                return `PSW_WMASK;
            end
            default: begin
                return 8'hFF;
            end
        endcase
    endfunction

    // Bit address to byte address; low half lands in 0x20-0x2F
    function automatic logic [7:0] bit_byte(input logic [7:0] ba);
        if (ba[7]) begin
            return {ba[7:3], 3'b000};
        end
        return {`BITAREA_HI, ba[6:3]};
    endfunction

    function automatic xregion_e xregion(input logic [15:0] a);
        if (a <= `XR_SHARED_HI) begin
            return XR_SHARED;
        end
        if (a >= `XR_CFG_LO && a <= `XR_CFG_HI) begin
            return XR_CFG;
        end
        if (a >= `XR_BATT_LO && a <= `XR_BATT_HI) begin
            return XR_BATT;
        end
        return XR_NONE;
    endfunction

    assign acc = sfr_ff[ix(`SFR_ACCUM)];
    assign sp = sfr_ff[ix(`SFR_STACK)];
    assign bank_sel = sfr_ff[ix(`SFR_STATUS_WORD)][4:3];
    assign accumulator = acc;
    assign psw_view = {sfr_ff[ix(`SFR_STATUS_WORD)][7:1], ^acc};

    // Selection only steers the address; both pointers keep their values
    assign data_pointer_zero_sel = sfr_ff[ix(`SFR_PTR_SEL)][`PTR_SEL_BIT] ?
        {sfr_ff[ix(`SFR_DP1_HI)], sfr_ff[ix(`SFR_DP1_LO)]} :
        {sfr_ff[ix(`SFR_DP0_HI)], sfr_ff[ix(`SFR_DP0_LO)]};

    assign ri_val = iram_ff[{3'b000, bank_sel, 2'b00, xreq.ri_sel}];
    assign x_addr = xreq.use_data_pointer_zero ? data_pointer_zero_sel :
        {sfr_ff[ix(`SFR_XPAGE)], ri_val};

    // Unimplemented addresses read as zero
    always_comb begin
        if (!sfr_impl(int_req.addr)) begin
            sfr_rd = 8'h00;
        end else if (int_req.addr == `SFR_STATUS_WORD) begin
            sfr_rd = psw_view;
        end else begin
            sfr_rd = sfr_ff[ix(int_req.addr)];
        end
    end

    assign bit_tgt = bit_byte(int_req.addr);
    assign bit_old = bit_tgt[7] ? (bit_tgt == `SFR_STATUS_WORD ? psw_view :
        sfr_ff[ix(bit_tgt)]) : iram_ff[bit_tgt];
    always_comb begin
        bit_new = bit_old;
        bit_new[int_req.addr[2:0]] = int_req.wdata[0];
    end

    // Upper half splits by addressing mode
    assign sfr_wr = int_req.valid && int_req.wr && !int_req.bit_op &&
        !int_req.indirect && int_req.addr[7] && sfr_impl(int_req.addr);
    assign iram_wr = int_req.valid && int_req.wr && !int_req.bit_op &&
        (int_req.indirect || !int_req.addr[7]);
    assign bit_wr_sfr = int_req.valid && int_req.wr && int_req.bit_op &&
        bit_tgt[7] && sfr_impl(bit_tgt);
    assign bit_wr_iram = int_req.valid && int_req.wr && int_req.bit_op &&
        !bit_tgt[7];

    assign x_start = xreq.valid && xstate_ff == X_IDLE;
    assign xbusy = xstate_ff != X_IDLE;

    // Register file; hardware updates come last so they win a same-cycle write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 128; i++) begin
                sfr_ff[i] <= sfr_rst(8'(i + 128));
            end
        end else if (clk_en) begin
            if (sfr_wr) begin
                sfr_ff[ix(int_req.addr)] <=
                    (sfr_ff[ix(int_req.addr)] & ~sfr_wmask(int_req.addr)) |
                    (int_req.wdata & sfr_wmask(int_req.addr));
            end
            if (bit_wr_sfr) begin
                sfr_ff[ix(bit_tgt)] <= (sfr_ff[ix(bit_tgt)] & ~sfr_wmask(bit_tgt)) |
                    (bit_new & sfr_wmask(bit_tgt));
            end
            if (flag_upd.we) begin
                sfr_ff[ix(`SFR_STATUS_WORD)][`PSW_CARRY] <= flag_upd.carry;
                sfr_ff[ix(`SFR_STATUS_WORD)][`PSW_AUX] <= flag_upd.aux;
                sfr_ff[ix(`SFR_STATUS_WORD)][`PSW_WRAP] <= flag_upd.wrap;
            end
            if (muldiv_we) begin
                sfr_ff[ix(`SFR_ACCUM)] <= muldiv_acc;
                sfr_ff[ix(`SFR_MUL_AUX)] <= muldiv_aux;
            end
            if (xstate_ff == X_WAIT && xrdata_valid) begin
                sfr_ff[ix(`SFR_ACCUM)] <= xrdata;
            end
            if (stack_push) begin
                sfr_ff[ix(`SFR_STACK)] <= sp + 8'h01;
            end else if (stack_pop) begin
                sfr_ff[ix(`SFR_STACK)] <= sp - 8'h01;
            end
        end
    end

    // Internal RAM, 256 bytes; upper half only by indirect access
    always_ff @(posedge clk) begin
        if (clk_en && !sys_rst) begin
            if (iram_wr) begin
                iram_ff[int_req.addr] <= int_req.wdata;
            end
            if (bit_wr_iram) begin
                iram_ff[bit_tgt] <= bit_new;
            end
            if (stack_push) begin
                iram_ff[sp + 8'h01] <= push_data;
            end
        end
    end

    // Read port; a pop takes the port ahead of a core read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_rdata_ff <= 8'h00;
            int_rvalid_ff <= 1'b0;
        end else if (clk_en) begin
            int_rvalid_ff <= (int_req.valid && !int_req.wr) || stack_pop;
            if (stack_pop) begin
                int_rdata_ff <= iram_ff[sp];
            end else if (int_req.valid && !int_req.wr) begin
                if (int_req.bit_op) begin
                    int_rdata_ff <= {7'h00, bit_old[int_req.addr[2:0]]};
                end else if (int_req.addr[7] && !int_req.indirect) begin
                    int_rdata_ff <= sfr_rd;
                end else begin
                    int_rdata_ff <= iram_ff[int_req.addr];
                end
            end
        end
    end
    assign int_rdata = int_rdata_ff;
    assign int_rvalid = int_rvalid_ff;

    always_comb begin
        case (xstate_ff)
            X_IDLE: begin
                nxt_xstate = (x_start && !xreq.wr) ? X_WAIT : X_IDLE;
            end
            X_WAIT: begin
                nxt_xstate = xrdata_valid ? X_IDLE : X_WAIT;
            end
            default: begin
                nxt_xstate = X_IDLE;
            end
        endcase
    end

    // External data strobe: one cycle, store data is the accumulator
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xstate_ff <= X_IDLE;
            xbus_ff <= '0;
        end else if (clk_en) begin
            xstate_ff <= nxt_xstate;
            xbus_ff.valid <= x_start;
            if (x_start) begin
                xbus_ff.wr <= xreq.wr;
                xbus_ff.addr <= x_addr;
                xbus_ff.wdata <= acc;
                xbus_ff.region <= xregion(x_addr);
            end
        end
    end
    assign xbus = xbus_ff;

    // Program counter; wraps inside the full 64 KB space
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_ff <= `RESET_VECTOR;
        end else if (clk_en) begin
            if (irq_take) begin
                pc_ff <= `VEC_FIRST + {{(13 - VEC_W){1'b0}}, irq_index, 3'b000};
            end else if (pc_load) begin
                pc_ff <= pc_target;
            end else if (pc_inc) begin
                pc_ff <= pc_ff + 16'h0001;
            end
        end
    end
    assign fetch_addr = pc_ff;

    assign ce_lo = {1'b0, CE_BASE_KB[5:0], 10'h000};
    assign ce_end = ce_lo + {5'h00, CE_SIZE_KB[1:0], 10'h000};
    assign code_next = {1'b0, movc_use_pc ? pc_ff : data_pointer_zero_sel} + {9'h000, acc};

    // Code-table reads; the engine window flags its own program area
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code_addr_ff <= 16'h0000;
            code_in_ce_ff <= 1'b0;
        end else if (clk_en && movc_req) begin
            code_addr_ff <= code_next[15:0];
            code_in_ce_ff <= {1'b0, code_next[15:0]} >= ce_lo &&
                {1'b0, code_next[15:0]} < ce_end;
        end
    end
    assign code_addr = code_addr_ff;
    assign code_in_ce = code_in_ce_ff;

endmodule

//--- mpu_memory_map_map.svh
// Offsets, fields, reset values and map limits for the core memory decoder
//Contract
//- Program space covers 0x0000-0xFFFF for fetches and code-table reads.
//- Fetching starts at program address 0x0000 after reset.
//- Interrupt entries start at 0x0003, each 8 bytes above the previous.
//- Flash also holds the engine program, at most 3 KB, 1 KB aligned.
//- External 0x0000-0x13FF is 5 KB RAM shared with the engine.
//- External 0x2000-0x27FF is config RAM; 0x2800-0x287F is battery config RAM.
//- External moves store from and load into the accumulator.
//- Register-indirect: bank R0/R1 gives low byte, page register the high byte.
//- Pointer-indirect: the selected 16-bit data pointer gives the whole address.
//- Select bit 0 picks pointer zero or one; toggling keeps both values.
//- Internal data memory is 256 bytes with a one-byte address.
//- Upper half: direct reaches registers, indirect reaches upper RAM.
//- Lower 128 bytes reachable by direct and indirect addressing.
//- Bytes 0x00-0x1F are four banks of eight, picked by two status bits.
//- Bytes 0x20-0x2F are bit addressable; 0x30-0x7F byte only.
//- Unimplemented register reads are undefined; writes do nothing.
//- Registers at addresses with low three bits zero are bit addressable.
//- Multiply-aux register serves multiply/divide and general scratch use.
//- Only bit 7 of the baud-source register is implemented.
//- Stack pointer resets to 0x07 and increments before each store.
//- Status bit 2 is overflow; bit 0 is accumulator even parity.
`ifndef MPU_MEMORY_MAP_MAP_SVH
`define MPU_MEMORY_MAP_MAP_SVH
`define SFR_GPIO_A 8'h80
`define SFR_STACK 8'h81
`define SFR_DP0_LO 8'h82
`define SFR_DP0_HI 8'h83
`define SFR_DP1_LO 8'h84
`define SFR_DP1_HI 8'h85
`define SFR_PWR_BAUD 8'h87
`define SFR_TMR_RUN 8'h88
`define SFR_TMR_MODE 8'h89
`define SFR_TMR0_LO 8'h8A
`define SFR_TMR1_LO 8'h8B
`define SFR_TMR0_HI 8'h8C
`define SFR_TMR1_HI 8'h8D
`define SFR_STRETCH 8'h8E
`define SFR_GPIO_B 8'h90
`define SFR_PTR_SEL 8'h92
`define SFR_SER0_CTL 8'h98
`define SFR_SER0_BUF 8'h99
`define SFR_IRQ_EN2 8'h9A
`define SFR_SER1_CTL 8'h9B
`define SFR_SER1_BUF 8'h9C
`define SFR_SER1_RL_LO 8'h9D
`define SFR_GPIO_C 8'hA0
`define SFR_IRQ_EN0 8'hA8
`define SFR_IRQ_PRI0 8'hA9
`define SFR_SER0_RL_LO 8'hAA
`define SFR_GPIO_D 8'hB0
`define SFR_IRQ_EN1 8'hB8
`define SFR_IRQ_PRI1 8'hB9
`define SFR_SER0_RL_HI 8'hBA
`define SFR_SER1_RL_HI 8'hBB
`define SFR_XPAGE 8'hBF
`define SFR_IRQ_REQ 8'hC0
`define SFR_EXT_POL 8'hC8
`define SFR_STATUS_WORD 8'hD0
`define SFR_BAUD_SRC 8'hD8
`define SFR_ACCUM 8'hE0
`define SFR_MUL_AUX 8'hF0
`define RST_GPIO 8'hFF
`define RST_STACK 8'h07
`define RST_STRETCH 8'h01
`define RST_SER0_RL_LO 8'hD9
`define RST_SERX_RL_HI 8'h03
`define PSW_CARRY 7
`define PSW_AUX 6
`define PSW_WRAP 2
`define PSW_PARITY 0
`define PSW_WMASK 8'hFE
`define PTR_SEL_BIT 0
`define BAUD_SRC_WMASK 8'h80
`define RESET_VECTOR 16'h0000
`define VEC_FIRST 16'h0003
`define XR_SHARED_HI 16'h13FF
`define XR_CFG_LO 16'h2000
`define XR_CFG_HI 16'h27FF
`define XR_BATT_LO 16'h2800
`define XR_BATT_HI 16'h287F
`define BITAREA_HI 4'h2
`endif

//--- mpu_memory_map_pkg.sv
// Types shared by the core memory decoder
package mpu_memory_map_pkg;
    typedef enum logic [1:0] {
        XR_SHARED = 2'b00,
        XR_CFG = 2'b01,
        XR_BATT = 2'b10,
        XR_NONE = 2'b11
    } xregion_e;
    typedef enum logic [0:0] {
        X_IDLE = 1'b0,
        X_WAIT = 1'b1
    } xstate_e;
    typedef struct packed {
        logic valid;
        logic wr;
        logic indirect;
        logic bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } int_req_s;
    typedef struct packed {
        logic valid;
        logic wr;
        logic use_data_pointer_zero;
        logic ri_sel;
    } xreq_s;
    typedef struct packed {
        logic valid;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
        xregion_e region;
    } xbus_s;
    typedef struct packed {
        logic we;
        logic carry;
        logic aux;
        logic wrap;
    } flag_upd_s;
endpackage

//--- mpu_memory_map_sfr_decode_sva.sv
// Port-level assertions for the core memory decoder
module mpu_memory_map_sfr_decode_chk
    import mpu_memory_map_pkg::*;
#(
    parameter int VEC_W = 4,
    parameter int CE_BASE_KB = 0,
    parameter int CE_SIZE_KB = 3
) (
    input wire logic clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire int_req_s int_req,
    input wire logic int_rvalid,
    input wire xreq_s xreq,
    input wire xbus_s xbus,
    input wire logic [7:0] xrdata,
    input wire logic xrdata_valid,
    input wire logic xbusy,
    input wire logic pc_load,
    input wire logic pc_inc,
    input wire logic irq_take,
    input wire logic [VEC_W-1:0] irq_index,
    input wire logic movc_req,
    input wire logic [15:0] fetch_addr,
    input wire logic [15:0] code_addr,
    input wire logic code_in_ce,
    input wire logic [7:0] accumulator
);
    localparam int CE_LO = CE_BASE_KB * 1024;
    localparam int CE_HI = (CE_BASE_KB + CE_SIZE_KB) * 1024;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    function automatic xregion_e region_of(input logic [15:0] a);
        if (a <= 16'h13FF) return XR_SHARED;
        if (a >= 16'h2000 && a <= 16'h27FF) return XR_CFG;
        if (a >= 16'h2800 && a <= 16'h287F) return XR_BATT;
        return XR_NONE;
    endfunction
    property p_rd_answer;
        clk_en && int_req.valid && !int_req.wr |=> int_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("internal read not answered");
    property p_start;
        $fell(sys_rst) |-> fetch_addr == 16'h0000;
    endproperty
    a_start: assert property (p_start) else $error("fetch did not start at zero");
    property p_vector;
        clk_en && irq_take |=> fetch_addr == 16'h0003 + (16'($past(irq_index)) << 3);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong service entry");
    property p_pc_step;
        clk_en && pc_inc && !pc_load && !irq_take |=> fetch_addr == $past(fetch_addr) + 16'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("fetch address did not step");
    property p_xsrc;
        $rose(xbus.valid) |-> $past(xreq.valid && !xbusy && clk_en);
    endproperty
    a_xsrc: assert property (p_xsrc) else $error("bus cycle without request");
    property p_region;
        xbus.valid |-> xbus.region == region_of(xbus.addr);
    endproperty
    a_region: assert property (p_region) else $error("wrong region");
    property p_busy;
        xbus.valid && !xbus.wr |-> xbusy;
    endproperty
    a_busy: assert property (p_busy) else $error("read not marked busy");
    property p_load;
        clk_en && xbusy && xrdata_valid |=> accumulator == $past(xrdata) && !xbusy;
    endproperty
    a_load: assert property (p_load) else $error("read data not loaded");
    property p_ce;
        clk_en && movc_req |=> code_in_ce == (int'(code_addr) >= CE_LO && int'(code_addr) < CE_HI);
    endproperty
    a_ce: assert property (p_ce) else $error("engine window flag wrong");
endmodule
bind mpu_memory_map_sfr_decode mpu_memory_map_sfr_decode_chk #(
    .VEC_W(VEC_W), .CE_BASE_KB(CE_BASE_KB), .CE_SIZE_KB(CE_SIZE_KB)
) chk_i (
    .clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .int_req(int_req), .int_rvalid(int_rvalid),
    .xreq(xreq), .xbus(xbus), .xrdata(xrdata), .xrdata_valid(xrdata_valid), .xbusy(xbusy),
    .pc_load(pc_load), .pc_inc(pc_inc), .irq_take(irq_take), .irq_index(irq_index),
    .movc_req(movc_req), .fetch_addr(fetch_addr), .code_addr(code_addr),
    .code_in_ce(code_in_ce), .accumulator(accumulator)
);

//--- mpu_memory_map_xdata_model.sv
// External data space model: shared RAM, config RAM and battery RAM
module mpu_memory_map_xdata_model
    import mpu_memory_map_pkg::*;
(
    input wire logic clk,
    input wire xbus_s xbus,
    input wire logic [3:0] lat,
    output logic [7:0] xrdata,
    output logic xrdata_valid
);
    logic [7:0] mem [0:16'h287F];
    logic [7:0] held = 8'h00;
    logic [3:0] wait_cnt = 4'h0;
    logic pending = 1'b0;
    function automatic logic hit(input logic [15:0] a);
        return a <= 16'h13FF || (a >= 16'h2000 && a <= 16'h287F);
    endfunction
    initial begin
        xrdata = 8'h00;
        xrdata_valid = 1'b0;
    end
    // Data line toggles outside the answer so a stale byte never looks valid
    always @(posedge clk) begin
        xrdata_valid <= 1'b0;
        xrdata <= ~xrdata;
        if (xbus.valid && xbus.wr && hit(xbus.addr)) begin
            mem[xbus.addr] <= xbus.wdata;
        end
        if (xbus.valid && !xbus.wr) begin
            pending <= 1'b1;
            wait_cnt <= lat;
            held <= hit(xbus.addr) ? mem[xbus.addr] : 8'hA5;
        end else if (pending && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (pending) begin
            pending <= 1'b0;
            xrdata_valid <= 1'b1;
            xrdata <= held;
        end
    end
endmodule

//--- mpu_memory_map_sfr_decode_bench.sv
// Self-checking bench for the core memory decoder and register file
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); \
    end \
end
module mpu_memory_map_sfr_decode_bench
    import mpu_memory_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, clk_en = 1'b1, sys_rst = 1'b1;
    int_req_s int_req = '0;
    xreq_s xreq = '0;
    xbus_s xbus;
    flag_upd_s flag_upd = '0;
    logic stack_push = 1'b0, stack_pop = 1'b0, pc_load = 1'b0, pc_inc = 1'b0, irq_take = 1'b0;
    logic movc_req = 1'b0, movc_use_pc = 1'b0, muldiv_we = 1'b0;
    logic int_rvalid, xrdata_valid, xbusy, code_in_ce;
    logic [7:0] push_data = 8'h00, muldiv_acc = 8'h00, muldiv_aux = 8'h00;
    logic [7:0] int_rdata, xrdata, accumulator;
    logic [15:0] pc_target = 16'h0000, fetch_addr, code_addr;
    logic [3:0] irq_index = 4'h0, lat = 4'h0;
    logic [1:0] bank_sel;
    int bad_count = 0, total_checks = 0;
    logic [15:0] rst_tab [38] = '{16'h80FF, 16'h8107, 16'h8200, 16'h8300, 16'h8400, 16'h8500,
        16'h8700, 16'h8800, 16'h8900, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00, 16'h8E01,
        16'h90FF, 16'h9200, 16'h9800, 16'h9900, 16'h9A00, 16'h9B00, 16'h9C00, 16'h9D00,
        16'hA0FF, 16'hA800, 16'hA900, 16'hAAD9, 16'hB0FF, 16'hB800, 16'hB900, 16'hBA03,
        16'hBB03, 16'hBF00, 16'hC000, 16'hC800, 16'hD000, 16'hD800, 16'hE000, 16'hF000};
    mpu_memory_map_sfr_decode #(.VEC_W(4), .CE_BASE_KB(0), .CE_SIZE_KB(3)) uut (
        .clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .int_req(int_req),
        .int_rdata(int_rdata), .int_rvalid(int_rvalid), .stack_push(stack_push),
        .stack_pop(stack_pop), .push_data(push_data), .xreq(xreq), .xbus(xbus),
        .xrdata(xrdata), .xrdata_valid(xrdata_valid), .xbusy(xbusy), .pc_load(pc_load),
        .pc_target(pc_target), .pc_inc(pc_inc), .irq_take(irq_take), .irq_index(irq_index),
        .movc_req(movc_req), .movc_use_pc(movc_use_pc), .fetch_addr(fetch_addr),
        .code_addr(code_addr), .code_in_ce(code_in_ce), .flag_upd(flag_upd),
        .muldiv_we(muldiv_we), .muldiv_acc(muldiv_acc), .muldiv_aux(muldiv_aux),
        .accumulator(accumulator), .bank_sel(bank_sel));
    mpu_memory_map_xdata_model xmem (.clk(clk), .xbus(xbus), .lat(lat), .xrdata(xrdata),
        .xrdata_valid(xrdata_valid));
    always #20 clk = ~clk;
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic ia(input logic w, ind, bo, input logic [7:0] a, d);
        step();
        int_req = '{1'b1, w, ind, bo, a, d};
        step();
        int_req = '0;
    endtask
    task automatic rd(input logic ind, bo, input logic [7:0] a, e);
        logic [7:0] got;
        ia(1'b0, ind, bo, a, 8'h00);
        got = bo ? {7'h00, int_rdata[0]} : int_rdata;
        `CHK(int_rvalid, 1'b1)
        `CHK(got, e)
    endtask
    // Bounded wait so a lost answer cannot hang the run
    task automatic xf(input logic w, dp, ri, input logic [15:0] ea, input logic [7:0] ed);
        int n;
        xreq = '{1'b1, w, dp, ri};
        step();
        xreq = '0;
        `CHK(xbus.valid, 1'b1)
        `CHK(xbus.addr, ea)
        if (w) `CHK(xbus.wdata, ed)
        n = 0;
        while (xbusy !== 1'b0 && n < 40) begin
            step();
            n++;
        end
        `CHK(accumulator, ed)
    endtask
    task automatic fin(input string s);
        $display("test done: %s", s);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        `CHK(fetch_addr, 16'h0000)
        foreach (rst_tab[i]) rd(1'b0, 1'b0, rst_tab[i][15:8], rst_tab[i][7:0]);
        fin("reset values");
        ia(1, 0, 0, 8'h90, 8'h3C);
        ia(1, 1, 0, 8'h90, 8'hC3);
        rd(0, 0, 8'h90, 8'h3C);
        rd(1, 0, 8'h90, 8'hC3);
        ia(1, 0, 0, 8'h40, 8'h66);
        rd(1, 0, 8'h40, 8'h66);
        ia(1, 1, 0, 8'hFF, 8'h99);
        rd(1, 0, 8'hFF, 8'h99);
        ia(1, 0, 0, 8'h86, 8'h55);
        rd(0, 0, 8'h86, 8'h00);
        rd(0, 0, 8'h87, 8'h00);
        fin("address spaces");
        ia(1, 0, 0, 8'h20, 8'h00);
        ia(1, 0, 0, 8'h2F, 8'h00);
        ia(1, 0, 1, 8'h05, 8'h01);
        rd(0, 0, 8'h20, 8'h20);
        ia(1, 0, 1, 8'h7F, 8'h01);
        rd(0, 1, 8'h7F, 8'h01);
        rd(0, 0, 8'h2F, 8'h80);
        ia(1, 0, 1, 8'hF3, 8'h01);
        rd(0, 0, 8'hF0, 8'h08);
        fin("bit access");
        ia(1, 0, 0, 8'hE0, 8'h07);
        ia(1, 0, 0, 8'hD0, 8'hFE);
        rd(0, 0, 8'hD0, 8'hFF);
        for (int b = 0; b < 4; b++) begin
            ia(1, 0, 0, 8'hD0, 8'(b * 8));
            `CHK(bank_sel, 2'(b))
        end
        ia(1, 0, 0, 8'hD0, 8'h20);
        flag_upd = '{1'b1, 1'b1, 1'b0, 1'b1};
        step();
        flag_upd = '0;
        rd(0, 0, 8'hD0, 8'hA5);
        flag_upd = '{1'b1, 1'b0, 1'b1, 1'b0};
        rd(0, 0, 8'hD0, 8'h61);
        flag_upd = '0;
        ia(1, 0, 0, 8'hD8, 8'hFF);
        rd(0, 0, 8'hD8, 8'h80);
        muldiv_we = 1'b1;
        muldiv_acc = 8'h12;
        muldiv_aux = 8'h34;
        step();
        muldiv_we = 1'b0;
        rd(0, 0, 8'hF0, 8'h34);
        `CHK(accumulator, 8'h12)
        fin("status and scratch");
        push_data = 8'hAB;
        stack_push = 1'b1;
        step();
        stack_push = 1'b0;
        rd(0, 0, 8'h81, 8'h08);
        rd(1, 0, 8'h08, 8'hAB);
        stack_pop = 1'b1;
        step();
        stack_pop = 1'b0;
        `CHK(int_rdata, 8'hAB)
        rd(0, 0, 8'h81, 8'h07);
        fin("stack");
        ia(1, 0, 0, 8'hD0, 8'h10);
        ia(1, 0, 0, 8'h10, 8'h34);
        ia(1, 0, 0, 8'h11, 8'h7F);
        ia(1, 0, 0, 8'hBF, 8'h12);
        ia(1, 0, 0, 8'hE0, 8'h77);
        xf(1, 0, 0, 16'h1234, 8'h77);
        ia(1, 0, 0, 8'hE0, 8'h00);
        xf(0, 0, 0, 16'h1234, 8'h77);
        ia(1, 0, 0, 8'hBF, 8'h28);
        ia(1, 0, 0, 8'hE0, 8'h5E);
        xf(1, 0, 1, 16'h287F, 8'h5E);
        ia(1, 0, 0, 8'hE0, 8'h00);
        lat = 4'd6;
        xf(0, 0, 1, 16'h287F, 8'h5E);
        ia(1, 0, 0, 8'h83, 8'h20);
        ia(1, 0, 0, 8'h82, 8'h00);
        ia(1, 0, 0, 8'h85, 8'h13);
        ia(1, 0, 0, 8'h84, 8'hFF);
        ia(1, 0, 0, 8'hE0, 8'hC4);
        xf(1, 1, 0, 16'h2000, 8'hC4);
        ia(1, 0, 0, 8'h92, 8'h01);
        ia(1, 0, 0, 8'hE0, 8'h3B);
        xf(1, 1, 0, 16'h13FF, 8'h3B);
        ia(1, 0, 0, 8'h92, 8'h00);
        xf(0, 1, 0, 16'h2000, 8'hC4);
        rd(0, 0, 8'h84, 8'hFF);
        rd(0, 0, 8'h85, 8'h13);
        fin("external data");
        clk_en = 1'b0;
        pc_inc = 1'b1;
        step();
        clk_en = 1'b1;
        step();
        pc_inc = 1'b0;
        `CHK(fetch_addr, 16'h0001)
        irq_take = 1'b1;
        for (int i = 0; i < 16; i++) begin
            irq_index = 4'(i);
            step();
            `CHK(fetch_addr, 16'h0003 + 16'(i * 8))
        end
        irq_take = 1'b0;
        pc_target = 16'hFFFF;
        pc_load = 1'b1;
        step();
        pc_load = 1'b0;
        pc_inc = 1'b1;
        step();
        pc_inc = 1'b0;
        `CHK(fetch_addr, 16'h0000)
        ia(1, 0, 0, 8'h83, 8'h0B);
        ia(1, 0, 0, 8'h82, 8'hFF);
        for (int k = 0; k < 2; k++) begin
            ia(1, 0, 0, 8'hE0, 8'(k));
            movc_req = 1'b1;
            step();
            movc_req = 1'b0;
            `CHK(code_addr, 16'h0BFF + 16'(k))
            `CHK(code_in_ce, 1'(1 - k))
        end
        fin("program space");
        test_done();
    end
endmodule
